// *** hw/strap_pkg.sv ***
// constants for the strap capture block: register map, field positions, resets
// assumes a 32-bit AHB-Lite slave with word registers
package strap_pkg;
	localparam logic [7:0]  cfg_addr       = 8'h00; // led mode, reload request
	localparam logic [7:0]  straps_addr    = 8'h04; // raw captured strap levels
	localparam logic [7:0]  port1_addr     = 8'h08; // derived port 1 settings
	localparam logic [7:0]  port2_addr     = 8'h0C; // derived port 2 settings
	localparam int          led_mode_lsb   = 4;
	localparam int          led_mode_w     = 2;
	localparam logic [1:0]  led_mode_rst   = 2'h0;
	localparam int          reload_bit     = 0;
	localparam int          strap_w        = 8;
	// strap vector bit positions
	localparam int          s_p1_dpx       = 0;
	localparam int          s_p2_an        = 1;
	localparam int          s_p2_spd       = 2;
	localparam int          s_p2_dpx       = 3;
	localparam int          s_p2_ffc       = 4;
	localparam int          s_p1_ffc       = 5;
	localparam int          s_p1_spd       = 6;
	localparam int          s_p1_an        = 7;
	// default levels of the internal pulls: 1 = pull-up
	localparam logic [7:0]  strap_pull_dflt = 8'h5F;
	// derived setting word: an, speed100, full duplex, force flow control
	localparam int          f_an           = 0;
	localparam int          f_spd          = 1;
	localparam int          f_dpx          = 2;
	localparam int          f_ffc          = 3;
	localparam int          set_w          = 4;
	localparam logic [1:0]  htrans_nonseq  = 2'h2;
	localparam logic [31:0] zero_word      = 32'h0000_0000;
	typedef enum logic [2:0] {
		st_reset = 3'b001,
		st_hold  = 3'b010,
		st_run   = 3'b100
	} cap_state_t;
endpackage

// *** hw/strap_if.sv ***
// carrier between the capture core and its derivation unit
// assumes both sides on ref_clk
`timescale 1ns/10ps
interface strap_if;
	logic [7:0] straps;
	logic [3:0] port1_set;
	logic [3:0] port2_set;
	modport core (output straps, input port1_set, input port2_set);
	modport derive (input straps, output port1_set, output port2_set);
endinterface

// *** hw/strap_derive.sv ***
// derivation of per-port link defaults from captured strap levels
// assumes straps are stable registered levels
`timescale 1ns/10ps
module strap_derive
	import strap_pkg::*;
(
	strap_if.derive sif
);
	// port 1 settings word
	assign sif.port1_set[f_an]  = sif.straps[s_p1_an];
	assign sif.port1_set[f_spd] = sif.straps[s_p1_spd];
	assign sif.port1_set[f_dpx] = sif.straps[s_p1_dpx];
	assign sif.port1_set[f_ffc] = sif.straps[s_p1_ffc];
	// port 2 settings word
	assign sif.port2_set[f_an]  = sif.straps[s_p2_an];
	assign sif.port2_set[f_spd] = sif.straps[s_p2_spd];
	assign sif.port2_set[f_dpx] = sif.straps[s_p2_dpx];
	assign sif.port2_set[f_ffc] = sif.straps[s_p2_ffc];
endmodule

// *** hw/port_strap_config_latch.sv ***
// strap capture for the two copper ports, AHB-Lite register access
// assumes pad levels synchronous to ref_clk; the internal pull is applied here to pins with strap_driven low
`timescale 1ns/10ps

module port_strap_config_latch
	import strap_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// shared strap pins, input side
	input  wire logic        p3_rx_valid_pin_i,
	input  wire logic        p3_rx_bit3_pin_i,
	input  wire logic        p3_rx_bit2_pin_i,
	input  wire logic        p3_rx_bit1_pin_i,
	input  wire logic        p3_rx_bit0_pin_i,
	input  wire logic        serial_out_pin_i,
	input  wire logic        port1_speed_led_pin_i,
	input  wire logic        port1_linkact_led_pin_i,
	input  wire logic [7:0]  strap_driven,
	// port 1 LED indicator sources
	input  wire logic        port1_speed100,
	input  wire logic        port1_full_dpx,
	input  wire logic        port1_link,
	input  wire logic        port1_activity,
	// LED pins, output side; enable low means driving
	output logic             port1_speed_led_pin_o,
	output logic             port1_speed_led_pin_oe_n,
	output logic             port1_linkact_led_pin_o,
	output logic             port1_linkact_led_pin_oe_n,
	// derived settings
	output logic [3:0]       port1_settings,
	output logic [3:0]       port2_settings,
	output logic             straps_valid,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	strap_if sif ();

	cap_state_t        state_q;
	cap_state_t        state_d;
	logic [7:0]        straps_q;
	logic [1:0]        led_mode_q;
	logic [3:0]        p1_set_q;
	logic [3:0]        p2_set_q;
	logic              led_spd_q;
	logic              led_lnk_q;
	logic              wr_pend_q;
	logic              rd_pend_q;
	logic [7:0]        addr_q;
	logic [31:0]       rdata_q;
	logic [7:0]        pin_levels;
	logic [7:0]        resolved;
	logic              ahb_go;
	logic              cfg_wr;
	logic              reload;
	logic              pins_out;
	logic [31:0]       rd_mux;

	// register decoding used only by the read data path
	function automatic logic [31:0] read_word(input logic [7:0] a, input logic [1:0] mode,
		input logic [7:0] s, input logic [3:0] p1, input logic [3:0] p2);
		logic [31:0] w;
		w = zero_word;
		case (a)
			cfg_addr:    w[led_mode_lsb +: led_mode_w] = mode;
			straps_addr: w[strap_w-1:0] = s;
			port1_addr:  w[set_w-1:0] = p1;
			port2_addr:  w[set_w-1:0] = p2;
			default:     w = zero_word;
		endcase
		return w;
	endfunction

	// pin gather; unbacked pins take their internal pull level
	assign pin_levels = {port1_linkact_led_pin_i, port1_speed_led_pin_i, serial_out_pin_i,
		p3_rx_bit0_pin_i, p3_rx_bit1_pin_i, p3_rx_bit2_pin_i, p3_rx_bit3_pin_i,
		p3_rx_valid_pin_i};
	genvar gi;
	generate
		for (gi = 0; gi < strap_w; gi++)
		begin : g_pull
			assign resolved[gi] = strap_driven[gi] ? pin_levels[gi]
				: strap_pull_dflt[gi];
		end
	endgenerate

	// bus decode
	assign ahb_go   = hsel && hready && htrans[1];
	assign cfg_wr   = wr_pend_q && (addr_q == cfg_addr);
	assign reload   = cfg_wr && hwdata[reload_bit];
	assign pins_out = (state_q == st_run);
	assign rd_mux   = read_word(haddr, led_mode_q, straps_q, p1_set_q, p2_set_q);

	// capture sequencing; a reload request re-samples with pins released
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			st_reset: state_d = st_hold;
			st_hold:  state_d = st_run;
			st_run:   state_d = reload ? st_hold : st_run;
			default:  state_d = st_reset;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			state_q <= st_reset;
		else if (clk_en)
			state_q <= state_d;
	end

	// straps follow the pins during reset and in every state but st_run, and freeze in st_run
	always_ff @(posedge ref_clk)
	begin
		if (clk_en && (sys_rst || state_q != st_run))
			straps_q <= resolved;
	end

	assign sif.straps = straps_q;
	strap_derive u_derive (
		.sif (sif.derive)
	);

	// registered settings so outputs come from flops
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			p1_set_q <= 4'h0;
			p2_set_q <= 4'h0;
		end
		else if (clk_en)
		begin
			p1_set_q <= sif.port1_set;
			p2_set_q <= sif.port2_set;
		end
	end
	assign port1_settings = p1_set_q;
	assign port2_settings = p2_set_q;
	assign straps_valid   = pins_out;

	// LED function selection; the pins stay released while straps are sampled
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			led_spd_q <= 1'b0;
			led_lnk_q <= 1'b0;
		end
		else if (clk_en)
		begin
			case (led_mode_q)
				2'h0:
				begin
					led_spd_q <= port1_speed100;
					led_lnk_q <= port1_link | port1_activity;
				end
				2'h1:
				begin
					led_spd_q <= port1_link;
					led_lnk_q <= port1_activity;
				end
				2'h2:
				begin
					led_spd_q <= port1_full_dpx;
					led_lnk_q <= port1_link | port1_activity;
				end
				default:
				begin
					led_spd_q <= port1_speed100;
					led_lnk_q <= port1_full_dpx;
				end
			endcase
		end
	end
	assign port1_speed_led_pin_o      = led_spd_q;
	assign port1_linkact_led_pin_o    = led_lnk_q;
	assign port1_speed_led_pin_oe_n   = ~pins_out;
	assign port1_linkact_led_pin_oe_n = ~pins_out;

	// AHB-Lite data phase; zero wait states, always OKAY
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wr_pend_q  <= 1'b0;
			rd_pend_q  <= 1'b0;
			addr_q     <= 8'h00;
			rdata_q    <= zero_word;
			led_mode_q <= led_mode_rst;
		end
		else if (clk_en)
		begin
			wr_pend_q <= ahb_go && hwrite;
			rd_pend_q <= ahb_go && !hwrite;
			if (ahb_go)
				addr_q <= haddr;
			if (ahb_go && !hwrite)
				rdata_q <= rd_mux;
			if (cfg_wr)
				led_mode_q <= hwdata[led_mode_lsb +: led_mode_w];
		end
	end
	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// checks
	property p_hold_after_run;
		@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && state_q == st_run && !reload) ##1 (state_q == st_run) |-> $stable(straps_q);
	endproperty
	a_hold_after_run: assert property (p_hold_after_run) else $error("straps changed in run");

	property p_pins_released_reset;
		@(posedge ref_clk) $fell(sys_rst) |-> port1_speed_led_pin_oe_n && port1_linkact_led_pin_oe_n;
	endproperty
	a_pins_released_reset: assert property (p_pins_released_reset) else $error("led driven at release");

	property p_run_after_release;
		@(posedge ref_clk) disable iff (sys_rst)
		($fell(sys_rst) && clk_en) ##1 clk_en |=> pins_out;
	endproperty
	a_run_after_release: assert property (p_run_after_release) else $error("pins not handed back");

	property p_p1_an;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en |=> port1_settings[f_an] == $past(straps_q[s_p1_an]);
	endproperty
	a_p1_an: assert property (p_p1_an) else $error("port1 autoneg mismatch");

	property p_p1_dpx;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en |=> port1_settings[f_dpx] == $past(straps_q[s_p1_dpx]);
	endproperty
	a_p1_dpx: assert property (p_p1_dpx) else $error("port1 duplex mismatch");

	property p_p1_spd_ffc;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en |=> port1_settings[f_spd] == $past(straps_q[s_p1_spd])
			&& port1_settings[f_ffc] == $past(straps_q[s_p1_ffc]);
	endproperty
	a_p1_spd_ffc: assert property (p_p1_spd_ffc) else $error("port1 speed or flow mismatch");

	property p_p2_an_spd;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en |=> port2_settings[f_an] == $past(straps_q[s_p2_an])
			&& port2_settings[f_spd] == $past(straps_q[s_p2_spd]);
	endproperty
	a_p2_an_spd: assert property (p_p2_an_spd) else $error("port2 an or speed mismatch");

	property p_p2_dpx_ffc;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en |=> port2_settings[f_dpx] == $past(straps_q[s_p2_dpx])
			&& port2_settings[f_ffc] == $past(straps_q[s_p2_ffc]);
	endproperty
	a_p2_dpx_ffc: assert property (p_p2_dpx_ffc) else $error("port2 duplex or flow mismatch");

	property p_pull_default;
		@(posedge ref_clk) (sys_rst && clk_en && !strap_driven[s_p1_an])
			|=> straps_q[s_p1_an] == strap_pull_dflt[s_p1_an];
	endproperty
	a_pull_default: assert property (p_pull_default) else $error("pull default lost");

	// a reload hands the pins back after exactly one capture cycle
	property p_reload_window;
		@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && reload && state_q == st_run) ##1 clk_en |-> !pins_out ##1 pins_out;
	endproperty
	a_reload_window: assert property (p_reload_window) else $error("reload window wrong");

	// straps track the resolved pins on every enabled edge outside run
	property p_capture_follows;
		@(posedge ref_clk) (clk_en && (sys_rst || state_q != st_run))
			|=> straps_q == $past(resolved);
	endproperty
	a_capture_follows: assert property (p_capture_follows) else $error("straps not sampled");

	c_reload: cover property (@(posedge ref_clk) disable iff (sys_rst) reload);
	c_led_write: cover property (@(posedge ref_clk) disable iff (sys_rst) cfg_wr);
	c_read: cover property (@(posedge ref_clk) disable iff (sys_rst) rd_pend_q);
	c_release: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(pins_out));
endmodule

// *** test/strap_board.sv ***
// board model: strap resistors on the shared pins of the capture block
// assumes LED pins read back the device's own level while it drives them
`timescale 1ns/10ps
module strap_board
	import strap_pkg::*;
(
	input  wire logic [7:0] fitted,
	input  wire logic [7:0] level,
	input  wire logic       spd_o,
	input  wire logic       spd_oe_n,
	input  wire logic       la_o,
	input  wire logic       la_oe_n,
	output logic [7:0]      pad,
	output logic [7:0]      strap_driven
);
	logic [7:0] raw;
	// unfitted pin floats: show the inverse of the pull so a wrong pick shows up
	assign raw = (fitted & level) | (~fitted & ~strap_pull_dflt);
	assign strap_driven = fitted;
	// a driven LED pin overrides its resistor; released, it shows the resistor level
	assign pad = {la_oe_n ? raw[7] : la_o, spd_oe_n ? raw[6] : spd_o, raw[5:0]};
endmodule

// *** test/tb_top.sv ***
// self-checking bench: strap capture, derived settings, LED modes over AHB-Lite
// assumes the board model supplies pad levels; hsize held fixed
`timescale 1ns/10ps
module tb_top import strap_pkg::*;;
	logic        ref_clk, sys_rst, hsel, hwrite, hready, spd_o, spd_oe_n, la_o, la_oe_n, sv;
	logic        ce, hresp;
	logic [7:0]  fitted, level, pad, drv, haddr, pat;
	logic [3:0]  p1s, p2s, src;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata;
	int          mismatches, tests_run, i, m;

	// core clock, 5 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	strap_board i_board (.fitted(fitted), .level(level), .spd_o(spd_o), .spd_oe_n(spd_oe_n),
		.la_o(la_o), .la_oe_n(la_oe_n), .pad(pad), .strap_driven(drv));

	port_strap_config_latch i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(ce),
		.p3_rx_valid_pin_i(pad[0]), .p3_rx_bit3_pin_i(pad[1]), .p3_rx_bit2_pin_i(pad[2]),
		.p3_rx_bit1_pin_i(pad[3]), .p3_rx_bit0_pin_i(pad[4]), .serial_out_pin_i(pad[5]),
		.port1_speed_led_pin_i(pad[6]), .port1_linkact_led_pin_i(pad[7]), .strap_driven(drv),
		.port1_speed100(src[0]), .port1_full_dpx(src[1]), .port1_link(src[2]),
		.port1_activity(src[3]), .port1_speed_led_pin_o(spd_o),
		.port1_speed_led_pin_oe_n(spd_oe_n), .port1_linkact_led_pin_o(la_o),
		.port1_linkact_led_pin_oe_n(la_oe_n), .port1_settings(p1s), .port2_settings(p2s),
		.straps_valid(sv), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp));

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// one single word transfer; the bus waits on hready, never on a fixed count
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1; haddr <= a; htrans <= htrans_nonseq; hwrite <= wr;
		@(posedge ref_clk);
		while (hready !== 1'b1) @(posedge ref_clk);
		htrans <= 2'h0; hwdata <= d;
		@(posedge ref_clk);
		while (hready !== 1'b1) @(posedge ref_clk);
		chk(zero_word, {31'h0, hresp});
		if (!wr) chk(d, hrdata);
	endtask

	// reset with pins pulled as set; pins must stay released during reset and be driven once straps are valid
	task automatic do_reset();
		sys_rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk(32'h3, {spd_oe_n, la_oe_n});
		sys_rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(32'h2, {sv, spd_oe_n | la_oe_n});
	endtask

	function automatic logic [31:0] set1(input logic [7:0] s);
		return {28'h0, s[s_p1_ffc], s[s_p1_dpx], s[s_p1_spd], s[s_p1_an]};
	endfunction

	function automatic logic [31:0] set2(input logic [7:0] s);
		return {28'h0, s[s_p2_ffc], s[s_p2_dpx], s[s_p2_spd], s[s_p2_an]};
	endfunction

	// expected {speed pin, link pin} per LED mode
	function automatic logic [31:0] led(input int md, input logic [3:0] s);
		case (md)
			0: return {30'h0, s[0], s[2] | s[3]};
			1: return {30'h0, s[2], s[3]};
			2: return {30'h0, s[1], s[2] | s[3]};
			default: return {30'h0, s[0], s[1]};
		endcase
	endfunction

	task automatic end_sim();
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		end_sim();
	end

	initial
	begin
		sys_rst = 1'b1; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
		hwdata = 32'h0; fitted = 8'h00; level = 8'h00; src = 4'h0;
		mismatches = 0; tests_run = 0;
		ce = 1'b1;
		do_reset();
		xfer(1'b0, straps_addr, {24'h0, strap_pull_dflt});
		chk(set1(strap_pull_dflt), {28'h0, p1s});
		chk(set2(strap_pull_dflt), {28'h0, p2s});
		$display("test internal pulls done");
		// each strap alone high, then all low and all high, every resistor fitted
		for (i = 0; i < 10; i++)
		begin
			pat = (i == 8) ? 8'h00 : (i == 9) ? 8'hFF : 8'h01 << i;
			fitted <= 8'hFF;
			level <= pat;
			do_reset();
			xfer(1'b0, straps_addr, {24'h0, pat});
			xfer(1'b0, port1_addr, set1(pat));
			xfer(1'b0, port2_addr, set2(pat));
			chk(set1(pat), {28'h0, p1s});
			chk(set2(pat), {28'h0, p2s});
		end
		$display("test strap levels done");
		// pins move after release: captured levels must hold
		level <= ~pat;
		repeat (5) @(posedge ref_clk);
		xfer(1'b0, straps_addr, {24'h0, pat});
		chk(set2(pat), {28'h0, p2s});
		$display("test hold done");
		// every LED mode against every source pattern
		for (m = 0; m < 4; m++)
		begin
			xfer(1'b1, cfg_addr, m << led_mode_lsb);
			xfer(1'b0, cfg_addr, m << led_mode_lsb);
			for (i = 0; i < 16; i++)
			begin
				src <= i[3:0];
				repeat (3) @(posedge ref_clk);
				chk(led(m, i[3:0]), {30'h0, spd_o, la_o});
			end
		end
		xfer(1'b1, 8'h10, 32'h0000_0010);
		xfer(1'b0, 8'h10, zero_word);
		xfer(1'b0, cfg_addr, 32'h0000_0030);
		$display("test led modes done");
		// a reload re-samples the straps with the LED pins released
		level <= 8'hA5;
		xfer(1'b1, cfg_addr, 32'h0000_0031);
		xfer(1'b0, straps_addr, 32'h0000_00A5);
		chk(set1(8'hA5), {28'h0, p1s});
		chk(set2(8'hA5), {28'h0, p2s});
		$display("test reload done");
		// clock enable low freezes the LED flops
		ce <= 1'b0;
		src <= 4'h0;
		repeat (3) @(posedge ref_clk);
		chk(led(3, 4'hF), {30'h0, spd_o, la_o});
		ce <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(led(3, 4'h0), {30'h0, spd_o, la_o});
		$display("test clock enable done");
		end_sim();
	end
endmodule
